/* File: simd_fp_exception_dispatch.sv */
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
// Functional notes
// (RULE_01) Masked exception: default result, no signal
// (RULE_02) Masked exception sets sticky status flag
// (RULE_03) Packed flags keep no element identity
// (RULE_04) Unmasked exception signals vector 19
// (RULE_05) Old set flag never triggers dispatch
// (RULE_06) Dispatch on offending instruction, immediately; here only from ST_IDLE, a hit in another state is never dispatched
// (RULE_07) No software synchronisation needed
// (RULE_08) Software installs descriptor entry beforehand
// (RULE_09) Interrupt-gate entry clears interrupt enable
// (RULE_10) Packed flags are OR of elements
// (RULE_11) Pre- and post-computation class split
// (RULE_12) Unmasked post-computation: no result write
// (RULE_13) Request when raised AND NOT mask nonzero
module simd_fp_exception_dispatch
(
  input  wire logic                         clock_in,
  input  wire logic                         rst_in,
  // Execution pipeline report
  input  wire simd_fp_exc_pkg::exec_report_t pre_report_in,
  input  wire simd_fp_exc_pkg::exec_report_t post_report_in,
  output logic                              result_write_en_out,
  output logic                              default_result_out,
  // Exception vectoring
  output simd_fp_exc_pkg::dispatch_t        dispatch_out,
  input  wire logic                         dispatch_ack_in,
  input  wire logic                         interrupt_gate_in,
  input  wire logic                         handler_return_in,
  input  wire logic                         if_restore_in,
  input  wire logic                         if_restore_value_in,
  output logic                              interrupt_enable_out,
  // Avalon-MM slave
  input  wire logic [3:0]                   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic [31:0]                       avs_readdata,
  output logic                              avs_waitrequest,
  output logic                              irq_out
);

  logic [5:0]  flags_reg;
  logic [5:0]  flags_next;
  logic [5:0]  masks_reg;
  logic [5:0]  masks_next;
  logic [1:0]  irq_status_reg;
  logic [1:0]  irq_status_next;
  logic [1:0]  irq_mask_reg;
  logic [31:0] readdata_reg;
  logic        ack_reg;
  logic        if_reg;
  logic [5:0]  disp_classes_reg;
  logic        disp_post_reg;
  logic        result_we_reg;
  logic        default_res_reg;
  simd_fp_exc_pkg::disp_state_t state_reg;
  simd_fp_exc_pkg::disp_state_t state_next;

  logic [5:0] pre_raw;
  logic [5:0] post_raw;
  logic [5:0] pre_raised;
  logic [5:0] post_raised;
  logic [5:0] raised;
  logic [5:0] unmasked_hit;
  logic [5:0] masked_hit;
  logic       exc_request;
  logic       any_masked;
  logic       post_request;
  logic       accept_dispatch;

  function automatic logic [5:0] unmasked_of(input logic [5:0] cls,
                                             input logic [5:0] msk);
    unmasked_of = cls & ~msk;
  endfunction : unmasked_of

  // One-hot register select, shared by the write strobes and the read mux
  function automatic logic [3:0] decode_addr(input logic [3:0] addr);
    decode_addr = 4'h0;
    case (addr)
      simd_fp_exc_pkg::ADDR_CTRL_STATUS: decode_addr[0] = 1'b1;
      simd_fp_exc_pkg::ADDR_IRQ_STATUS:  decode_addr[1] = 1'b1;
      simd_fp_exc_pkg::ADDR_IRQ_MASK:    decode_addr[2] = 1'b1;
      simd_fp_exc_pkg::ADDR_DISPATCH:    decode_addr[3] = 1'b1;
      default:                           decode_addr = 4'h0;
    endcase
  endfunction : decode_addr

  lane_or_reduce u_pre_reduce
  (
    .lane_exc_in  (pre_report_in.lane_exc),
    .lane_en_in   (pre_report_in.lane_en),
    .packed_op_in (pre_report_in.packed_op),
    .classes_out  (pre_raw)
  );

  lane_or_reduce u_post_reduce
  (
    .lane_exc_in  (post_report_in.lane_exc),
    .lane_en_in   (post_report_in.lane_en),
    .packed_op_in (post_report_in.packed_op),
    .classes_out  (post_raw)
  );

  // (RULE_11) pre/post class filtering
  assign pre_raised  = pre_report_in.valid
                       ? (pre_raw & simd_fp_exc_pkg::PRE_CLASS_MASK) : 6'h00;
  // An unmasked fault before computation stops the post stage of that instruction
  assign post_raised = (post_report_in.valid &&
                        unmasked_of(pre_raised, masks_reg) == 6'h00)
                       ? (post_raw & simd_fp_exc_pkg::POST_CLASS_MASK)
                       : 6'h00;
  assign raised      = pre_raised | post_raised;

  // (RULE_13) request from new conditions
  // (RULE_05) only freshly raised bits count
  assign unmasked_hit = unmasked_of(raised, masks_reg);
  assign masked_hit   = raised & masks_reg;
  assign exc_request  = (unmasked_hit != 6'h00);
  assign any_masked   = (masked_hit != 6'h00);
  assign post_request = (unmasked_of(post_raised, masks_reg) != 6'h00);

  // (RULE_06) accepted in the report's cycle when idle; dispatch_out.valid rises on the next edge
  // (RULE_07) no sync instruction required
  assign accept_dispatch = exc_request &&
                           (state_reg == simd_fp_exc_pkg::ST_IDLE);

  // Only the first cycle of a request changes state, so a request held
  // through its wait state writes once and clears on read once
  logic       bus_first;
  logic [3:0] reg_sel;
  logic       bus_wr_cs;
  logic       bus_rd_irq;
  logic       wr_cs_low;
  logic       wr_cs_high;
  logic       wr_irq_mask;
  logic       rd_capture;
  assign bus_first   = (avs_read || avs_write) && !ack_reg;
  assign reg_sel     = decode_addr(avs_address);
  assign bus_wr_cs   = avs_write && bus_first && reg_sel[0];
  assign bus_rd_irq  = avs_read && bus_first && reg_sel[1];
  assign wr_cs_low   = bus_wr_cs && avs_byteenable[0];
  assign wr_cs_high  = bus_wr_cs && avs_byteenable[1];
  assign wr_irq_mask = avs_write && bus_first && reg_sel[2] &&
                       avs_byteenable[0];
  assign rd_capture  = avs_read && bus_first;

  // (RULE_02) sticky flags, set wins over clear
  always_comb
  begin
    flags_next = flags_reg;
    masks_next = masks_reg;
    if (wr_cs_low)
    begin
      flags_next = avs_writedata[simd_fp_exc_pkg::CS_FLAG_LSB +: 6];
    end
    if (wr_cs_low)
    begin
      masks_next[0] = avs_writedata[simd_fp_exc_pkg::CS_MASK_LSB];
    end
    if (wr_cs_high)
    begin
      masks_next[5:1] = avs_writedata[simd_fp_exc_pkg::CS_MASK_LSB+1 +: 5];
    end
    // All raised classes are recorded; unmasked ones belong to the handler
    flags_next = flags_next | raised;
  end

  always_comb
  begin
    irq_status_next = irq_status_reg;
    if (bus_rd_irq)
    begin
      irq_status_next = 2'h0;
    end
    if (any_masked)
    begin
      irq_status_next[simd_fp_exc_pkg::IRQ_MASKED] = 1'b1;
    end
    if (accept_dispatch)
    begin
      irq_status_next[simd_fp_exc_pkg::IRQ_DISPATCH] = 1'b1;
    end
  end

  // A hit while a dispatch is pending is only recorded in the flags:
  // the running handler sees it there, so it is not dispatched again
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      simd_fp_exc_pkg::ST_IDLE:
      begin
        if (exc_request)
        begin
          state_next = simd_fp_exc_pkg::ST_DISPATCH;
        end
      end
      simd_fp_exc_pkg::ST_DISPATCH:
      begin
        if (dispatch_ack_in)
        begin
          state_next = simd_fp_exc_pkg::ST_HANDLER;
        end
      end
      simd_fp_exc_pkg::ST_HANDLER:
      begin
        if (handler_return_in)
        begin
          state_next = simd_fp_exc_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_next = simd_fp_exc_pkg::ST_IDLE;
      end
    endcase
  end

  logic [31:0] cs_word;
  logic [31:0] rd_mux;
  assign cs_word = {19'h00000, masks_reg, 1'b0, flags_reg};
  // Unmapped words read as zero; writes to them are dropped
  assign rd_mux  =
    reg_sel[0] ? cs_word :
    reg_sel[1] ? {30'h0, irq_status_reg} :
    reg_sel[2] ? {30'h0, irq_mask_reg} :
    reg_sel[3] ? {21'h0, state_reg, disp_classes_reg, 2'h0} :
    simd_fp_exc_pkg::UNMAPPED_DATA;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      flags_reg <= simd_fp_exc_pkg::CS_RESET[5:0];
      masks_reg <= simd_fp_exc_pkg::CS_RESET[12:7];
      irq_status_reg <= 2'h0;
      state_reg <= simd_fp_exc_pkg::ST_IDLE;
    end
    else
    begin
      flags_reg <= flags_next;
      masks_reg <= masks_next;
      irq_status_reg <= irq_status_next;
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      irq_mask_reg <= 2'h0;
      readdata_reg <= 32'h0;
      ack_reg <= 1'b0;
    end
    else
    begin
      // One wait state per access; ack drops as the master releases
      ack_reg <= bus_first;
      // Read data are caught once and held until the next read
      if (rd_capture)
      begin
        readdata_reg <= rd_mux;
      end
      if (wr_irq_mask)
      begin
        irq_mask_reg <= avs_writedata[1:0];
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      disp_classes_reg <= 6'h00;
      disp_post_reg <= 1'b0;
    end
    else if (accept_dispatch)
    begin
      disp_classes_reg <= unmasked_hit;
      disp_post_reg <= post_request;
    end
  end

  // (RULE_01) default result on masked only
  // (RULE_12) no result when unmasked exception
  // Masked and unmasked hits together write nothing: the handler
  // builds the whole result from the operands
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      result_we_reg <= 1'b0;
      default_res_reg <= 1'b0;
    end
    else
    begin
      result_we_reg <= (pre_report_in.valid || post_report_in.valid) &&
                       !exc_request;
      default_res_reg <= any_masked && !exc_request;
    end
  end

  // (RULE_09) gate entry clears interrupt enable
  // Gate entry beats a restore in the same cycle
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      if_reg <= 1'b0;
    end
    else if (state_reg == simd_fp_exc_pkg::ST_DISPATCH &&
             dispatch_ack_in && interrupt_gate_in)
    begin
      if_reg <= 1'b0;
    end
    else if (if_restore_in)
    begin
      if_reg <= if_restore_value_in;
    end
  end

  // (RULE_04) vector 19 toward vectoring logic
  // (RULE_08) descriptor assumed installed by software
  assign dispatch_out.valid  = (state_reg == simd_fp_exc_pkg::ST_DISPATCH);
  assign dispatch_out.vector = simd_fp_exc_pkg::SIMD_FP_VECTOR;
  assign dispatch_out.classes = disp_classes_reg;
  assign dispatch_out.suppress_result = disp_post_reg;

  assign result_write_en_out  = result_we_reg;
  assign default_result_out   = default_res_reg;
  assign interrupt_enable_out = if_reg;
  assign avs_readdata         = readdata_reg;
  assign avs_waitrequest      = (avs_read || avs_write) && !ack_reg;
  // Level output; it drops when software reads the status word or clears the matching IRQ mask bit
  assign irq_out              = (irq_status_reg & irq_mask_reg) != 2'h0;

endmodule : simd_fp_exception_dispatch

/* File: simd_fp_exc_pkg.sv */
package simd_fp_exc_pkg;

  localparam int unsigned NUM_CLASSES = 6;
  localparam int unsigned NUM_LANES   = 4;
  localparam int unsigned VEC_W       = 8;
  localparam int unsigned ADDR_W      = 4;

  // Exception class bit positions
  localparam int unsigned CLS_INVALID   = 0;
  localparam int unsigned CLS_DENORMAL  = 1;
  localparam int unsigned CLS_DIVZERO   = 2;
  localparam int unsigned CLS_OVERFLOW  = 3;
  localparam int unsigned CLS_UNDERFLOW = 4;
  localparam int unsigned CLS_INEXACT   = 5;

  localparam logic [5:0] PRE_CLASS_MASK  = 6'h07;
  localparam logic [5:0] POST_CLASS_MASK = 6'h38;

  localparam logic [7:0] SIMD_FP_VECTOR = 8'h13;

  // Register word addresses (byte address / 4)
  localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h1;
  localparam logic [3:0] ADDR_IRQ_MASK    = 4'h2;
  localparam logic [3:0] ADDR_DISPATCH    = 4'h3;

  // Control/status word layout: flags [5:0], masks [12:7]
  localparam int unsigned CS_FLAG_LSB = 0;
  localparam int unsigned CS_MASK_LSB = 7;
  localparam logic [31:0] CS_RESET    = 32'h0000_1f80;

  // Interrupt status bits
  localparam int unsigned IRQ_MASKED   = 0;
  localparam int unsigned IRQ_DISPATCH = 1;
  localparam int unsigned IRQ_W        = 2;

  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic                          valid;
    logic                          packed_op;
    logic [NUM_LANES-1:0]          lane_en;
    logic [NUM_LANES*NUM_CLASSES-1:0] lane_exc;
  } exec_report_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] vector;
    logic [5:0] classes;
    logic       suppress_result;
  } dispatch_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b001,
    ST_DISPATCH = 3'b010,
    ST_HANDLER  = 3'b100
  } disp_state_t;

endpackage : simd_fp_exc_pkg

/* File: lane_or_reduce.sv */
`timescale 1ns/1ps
module lane_or_reduce
(
  input  wire logic [23:0] lane_exc_in,
  input  wire logic [3:0]  lane_en_in,
  input  wire logic        packed_op_in,
  output logic      [5:0]  classes_out
);

  logic [5:0] lane_vec [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      // Scalar operations only look at lane 0
      assign lane_vec[g] = (lane_en_in[g] && (packed_op_in || g == 0))
                           ? lane_exc_in[g*6 +: 6] : 6'h00;
    end
  endgenerate

  // (RULE_10) OR across lanes
  // (RULE_03) lane identity dropped
  assign classes_out = lane_vec[0] | lane_vec[1] | lane_vec[2] | lane_vec[3];

endmodule : lane_or_reduce

/* File: dispatch_checker.sv */
`timescale 1ns/1ps
module dispatch_checker
(
  input wire logic                          clock_in,
  input wire logic                          rst_in,
  input wire simd_fp_exc_pkg::exec_report_t pre_report_in,
  input wire simd_fp_exc_pkg::exec_report_t post_report_in,
  input wire logic                          result_write_en_out,
  input wire logic                          default_result_out,
  input wire simd_fp_exc_pkg::dispatch_t    dispatch_out,
  input wire logic                          dispatch_ack_in,
  input wire logic                          interrupt_gate_in,
  input wire logic                          if_restore_in,
  input wire logic                          interrupt_enable_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  wire any_rep = pre_report_in.valid | post_report_in.valid;
  sequence new_dispatch;
    $rose(dispatch_out.valid);
  endsequence
  // Ack through a gate with no flag write racing it
  sequence gate_entry;
    dispatch_out.valid && dispatch_ack_in && interrupt_gate_in
      && !if_restore_in;
  endsequence
  vector_fixed_a: assert property (dispatch_out.valid |->
    dispatch_out.vector == 8'h13) else $error("bad vector");
  disp_cause_a: assert property (new_dispatch |->
    $past(any_rep)) else $error("dispatch without report");
  disp_no_write_a: assert property (new_dispatch |->
    !result_write_en_out && !default_result_out)
    else $error("result written on dispatch");
  default_cause_a: assert property (default_result_out |->
    $past(any_rep) && result_write_en_out) else $error("stray default");
  write_cause_a: assert property (result_write_en_out |->
    $past(any_rep)) else $error("stray result write");
  disp_hold_a: assert property (dispatch_out.valid &&
    !dispatch_ack_in |=> dispatch_out.valid) else $error("dispatch dropped");
  gate_clear_a: assert property (gate_entry |=>
    !interrupt_enable_out && !dispatch_out.valid) else $error("flag kept");
  post_class_a: assert property ((new_dispatch and
    dispatch_out.suppress_result) |-> (dispatch_out.classes & 6'h07) == 6'h00)
    else $error("pre class on post dispatch");
  class_set_a: assert property (dispatch_out.valid |->
    dispatch_out.classes != 6'h00) else $error("empty dispatch");
endmodule : dispatch_checker

bind simd_fp_exception_dispatch dispatch_checker chk
(
  .clock_in(clock_in), .rst_in(rst_in), .pre_report_in(pre_report_in),
  .post_report_in(post_report_in), .result_write_en_out(result_write_en_out),
  .default_result_out(default_result_out), .dispatch_out(dispatch_out),
  .dispatch_ack_in(dispatch_ack_in), .interrupt_gate_in(interrupt_gate_in),
  .if_restore_in(if_restore_in), .interrupt_enable_out(interrupt_enable_out)
);

/* File: vector_partner.sv */
`timescale 1ns/1ps
module vector_partner
#(
  parameter logic [7:0] INSTALLED_VEC = 8'h13
)
(
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       disp_valid_in,
  input  wire logic [7:0] disp_vector_in,
  input  wire logic [3:0] delay_in,
  output logic            ack_out,
  output logic            gate_out,
  output logic            ret_out,
  output logic            restore_out
);
  logic [3:0] cnt_reg;
  logic       busy_reg;
  always_ff @(posedge clock_in)
  begin
    ack_out <= 1'b0;
    ret_out <= 1'b0;
    restore_out <= 1'b0;
    if (rst_in)
    begin
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      gate_out <= 1'b0;
    end
    // only the installed entry is ever entered
    else if (disp_valid_in && !ack_out && !busy_reg
             && disp_vector_in == INSTALLED_VEC)
    begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg == delay_in)
      begin
        ack_out <= 1'b1;
        gate_out <= 1'b1;
        busy_reg <= 1'b1;
        cnt_reg <= 4'h0;
      end
    end
    else if (busy_reg)
    begin
      cnt_reg <= cnt_reg + 4'h1;
      // Return restores the interrupt flag to one
      if (cnt_reg == delay_in)
      begin
        ret_out <= 1'b1;
        restore_out <= 1'b1;
        busy_reg <= 1'b0;
        cnt_reg <= 4'h0;
      end
    end
  end
endmodule : vector_partner

/* File: simd_fp_exception_dispatch_tb.sv */
`timescale 1ns/1ps
module simd_fp_exception_dispatch_tb;
  logic clock_in = 0, rst_in = 1, rd = 0, wr = 0;
  logic [3:0] addr = 0, delay = 0;
  logic [31:0] wdata = 0, rdata, v;
  simd_fp_exc_pkg::exec_report_t pre = '0, post = '0;
  simd_fp_exc_pkg::dispatch_t disp;
  logic wen, dflt, ack, gate, ret, rest, ie, wreq, irq;
  int n_mismatch = 0, checked = 0, cycles = 0;
  always #2 clock_in = ~clock_in;
  simd_fp_exception_dispatch DUT (.clock_in(clock_in), .rst_in(rst_in),
    .pre_report_in(pre), .post_report_in(post), .result_write_en_out(wen),
    .default_result_out(dflt), .dispatch_out(disp), .dispatch_ack_in(ack),
    .interrupt_gate_in(gate), .handler_return_in(ret), .if_restore_in(rest),
    .if_restore_value_in(1'b1), .interrupt_enable_out(ie),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .irq_out(irq));
  vector_partner partner (.clock_in(clock_in), .rst_in(rst_in),
    .disp_valid_in(disp.valid), .disp_vector_in(disp.vector),
    .delay_in(delay), .ack_out(ack), .gate_out(gate), .ret_out(ret),
    .restore_out(rest));
  task results;
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clock_in); while (wreq !== 1'b0);
    v = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  function automatic simd_fp_exc_pkg::exec_report_t rep(input logic pk,
    input logic [3:0] en, input logic [23:0] exc);
    rep = '{1'b1, pk, en, exc};
  endfunction : rep
  task send(input simd_fp_exc_pkg::exec_report_t p, q);
    @(posedge clock_in);
    pre <= p;
    post <= q;
    @(posedge clock_in);
    pre <= '0;
    post <= '0;
    #1;
  endtask : send
  task wait_ret;
    for (int i = 0; i < 40 && ret !== 1'b1; i++) @(posedge clock_in);
    check(ret, 1);
    @(posedge clock_in);
    #1;
  endtask : wait_ret
  task t_reset;
    bus(0, 4'h0, 0); check(v, simd_fp_exc_pkg::CS_RESET);
    bus(1, 4'h9, 32'hffff_ffff);
    bus(0, 4'h9, 0); check(v, simd_fp_exc_pkg::UNMAPPED_DATA);
    bus(0, 4'h0, 0); check(v, simd_fp_exc_pkg::CS_RESET);
  endtask : t_reset
  task t_masked;
    bus(1, 4'h2, 32'h1);
    send(rep(0, 4'h1, 24'h000001), '0);
    check({dflt, wen, disp.valid}, 3'b110);
    @(posedge clock_in); #1 check(irq, 1);
    bus(0, 4'h0, 0); check(v, simd_fp_exc_pkg::CS_RESET | 32'h1);
    bus(0, 4'h1, 0); check(v, 32'h1);
    bus(0, 4'h1, 0); check(v, 32'h0);
    #1 check(irq, 0);
  endtask : t_masked
  task t_packed;
    bus(1, 4'h0, simd_fp_exc_pkg::CS_RESET);
    // Lane 2 is disabled and lane 1 of a scalar op is not looked at
    send(rep(0, 4'hf, 24'h000040), rep(1, 4'ha, 24'h808400));
    check(dflt, 1);
    bus(0, 4'h0, 0); check(v, simd_fp_exc_pkg::CS_RESET | 32'h30);
  endtask : t_packed
  task t_unmasked;
    bus(1, 4'h0, 0);
    send(rep(0, 4'h1, 24'h000001), '0);
    check({disp.valid, disp.vector}, 9'h113);
    check({disp.classes, disp.suppress_result, wen}, 8'h04);
    wait_ret;
    check(ie, 1);
    send(rep(0, 4'h1, 24'h0), '0);
    check({disp.valid, wen}, 2'b01);
  endtask : t_unmasked
  task t_post;
    delay <= 4'h5;
    send('0, rep(0, 4'h1, 24'h000008));
    check({disp.classes, disp.suppress_result, wen}, 8'h22);
    for (int i = 0; i < 40 && ack !== 1'b1; i++) @(posedge clock_in);
    check(ack, 1);
    @(posedge clock_in);
    #1 check(ie, 0);
    wait_ret;
    bus(0, 4'h0, 0); check(v, 32'h9);
    bus(0, 4'h1, 0); check(v, 32'h3);
    bus(0, 4'h3, 0); check(v, 32'h120);
  endtask : t_post
  task t_burst;
    bus(1, 4'h0, simd_fp_exc_pkg::CS_RESET);
    // Two reports on consecutive cycles, no synchronising step between
    @(posedge clock_in);
    pre <= rep(0, 4'h1, 24'h000001);
    send(rep(0, 4'h1, 24'h000004), '0);
    check({dflt, wen}, 2'b11);
    bus(0, 4'h0, 0); check(v, simd_fp_exc_pkg::CS_RESET | 32'h5);
  endtask : t_burst
  always @(posedge clock_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    t_reset();
    t_masked();
    t_packed();
    t_unmasked();
    t_post();
    t_burst();
    results();
  end
endmodule : simd_fp_exception_dispatch_tb
